// ### design/axd_pkg.sv
// Purpose: Shared constants for the auxiliary converter code register bank
// Assumes: Registers sit on a 32-bit classic Wishbone bus, one word each
// Notes:   Register indices are the printed offsets; byte address is index * 4
package axd_pkg;

	localparam int unsigned NUM_CH      = 4;
	localparam int unsigned CODE_W      = 10;
	localparam int unsigned LOW_W       = 2;
	localparam int unsigned HIGH_W      = 8;
	localparam int unsigned REG_W       = 8;
	localparam int unsigned IDX_W       = 7;
	localparam int unsigned WMC_W       = 6;
	localparam int unsigned IDX_LSB     = 2;

	// Register indices (word addresses)
	localparam logic [6:0] IDX_WAVE_MEMORY_CONTROL = 7'h0c;
	localparam logic [6:0] IDX_DAC1_CODE_LOW       = 7'h18;
	localparam logic [6:0] IDX_DAC1_CODE_HIGH      = 7'h19;
	localparam logic [6:0] IDX_DAC2_CODE_LOW       = 7'h1a;
	localparam logic [6:0] IDX_DAC2_CODE_HIGH      = 7'h1b;
	localparam logic [6:0] IDX_DAC3_CODE_LOW       = 7'h1c;
	localparam logic [6:0] IDX_DAC3_CODE_HIGH      = 7'h1d;
	localparam logic [6:0] IDX_DAC4_CODE_LOW       = 7'h1e;
	localparam logic [6:0] IDX_DAC4_CODE_HIGH      = 7'h1f;

	// Code bank address form: 0011 + channel select + low/high select
	localparam logic [3:0] CODE_BANK_PREFIX = 4'h3;
	localparam int unsigned PREFIX_LSB      = 3;
	localparam int unsigned CHSEL_LSB       = 1;
	localparam int unsigned HL_BIT          = 0;

	// Field positions in wave_memory_control
	localparam int unsigned WMC_SRC_SEL_BIT = 0;

	// Reset values
	localparam logic [1:0] LOW_RST  = 2'h0;
	localparam logic [7:0] HIGH_RST = 8'h00;
	localparam logic [9:0] CODE_RST = 10'h000;
	localparam logic [5:0] WMC_RST  = 6'h00;

endpackage : axd_pkg

// ### design/axd_code_regs.sv
// Purpose: Auxiliary converter code registers behind a classic Wishbone slave
// Assumes: Wave memory sample comes from logic on clk_i
// Notes:   Ack follows a request by one cycle; writes land on the edge that ends ack
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// [RQ1] Eight 8-bit RW registers, four channels
// [RQ2] Low write stores bits 1:0 only
// [RQ3] High write stores 7:0, loads converter
// [RQ4] Channel 1 load only when source select low
// [RQ5] Low bits kept across high writes
// [RQ6] Low reserved bits: host zero, read zero
// [RQ7] Low register reads return stored bits
// [RQ8] High register reads return stored bits
// [RQ9] Low even, high odd; pair-local update
// [RQ10] Address 0011, channel select, low/high bit
// [RQ11] Wave memory control: six bits, two reserved
// [RQ12] Channel 1 driven by wave memory when selected
// [RQ13] Converter loads all ten bits atomically
module axd_code_regs #(
	parameter int unsigned ADR_W = 32
) (
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire logic [ADR_W-1:0]      wb_adr_i,
	input  wire logic [31:0]           wb_dat_i,
	output logic      [31:0]           wb_dat_o,
	input  wire logic                  wb_we_i,
	input  wire logic [3:0]            wb_sel_i,
	input  wire logic                  wb_cyc_i,
	input  wire logic                  wb_stb_i,
	output logic                       wb_ack_o,
	input  wire logic [9:0]            wave_memory_data_i,
	output logic      [39:0]           converter_code_o,
	output logic      [9:0]            converter1_drive_o,
	output logic      [5:0]            wave_memory_control_o
);

	// Elaboration checks: the fixed decode and packing below rely on these
	if (ADR_W < axd_pkg::IDX_W + axd_pkg::IDX_LSB) begin : g_chk_adr
		$error("axd_code_regs: ADR_W too small for the register index");
	end

	if (axd_pkg::NUM_CH != 4) begin : g_chk_ch
		$error("axd_code_regs: two channel select bits serve four channels");
	end

	if (axd_pkg::LOW_W + axd_pkg::HIGH_W != axd_pkg::CODE_W) begin : g_chk_split
		$error("axd_code_regs: low and high parts must make one code");
	end

	if (axd_pkg::LOW_W < 1) begin : g_chk_low_min
		$error("axd_code_regs: low part needs at least one bit");
	end

	if (axd_pkg::HIGH_W != axd_pkg::REG_W) begin : g_chk_high
		$error("axd_code_regs: high part must fill a register");
	end

	if (axd_pkg::LOW_W > axd_pkg::REG_W) begin : g_chk_low
		$error("axd_code_regs: low part wider than a register");
	end

	if (axd_pkg::WMC_W > axd_pkg::REG_W) begin : g_chk_wmc
		$error("axd_code_regs: control field wider than a register");
	end

	if (axd_pkg::REG_W > 32) begin : g_chk_bus
		$error("axd_code_regs: register wider than the bus");
	end

	if (axd_pkg::WMC_SRC_SEL_BIT >= axd_pkg::WMC_W) begin : g_chk_src
		$error("axd_code_regs: source select outside the control field");
	end

	if (axd_pkg::WMC_W != $bits(wave_memory_control_o)) begin : g_chk_wmc_port
		$error("axd_code_regs: control port width mismatch");
	end

	if (axd_pkg::CODE_W != $bits(converter1_drive_o)) begin : g_chk_drv_port
		$error("axd_code_regs: drive port width mismatch");
	end

	if (axd_pkg::CODE_W != $bits(wave_memory_data_i)) begin : g_chk_wave_port
		$error("axd_code_regs: wave sample width mismatch");
	end

	if (axd_pkg::CODE_W * axd_pkg::NUM_CH != $bits(converter_code_o)) begin : g_chk_code_port
		$error("axd_code_regs: converter code port width mismatch");
	end

	// Index layout: prefix, channel select, low/high bit
	if (axd_pkg::IDX_W != axd_pkg::PREFIX_LSB + $bits(axd_pkg::CODE_BANK_PREFIX)) begin : g_chk_pfx
		$error("axd_code_regs: prefix does not reach the index top");
	end

	if (axd_pkg::CHSEL_LSB != axd_pkg::HL_BIT + 1) begin : g_chk_hl
		$error("axd_code_regs: channel select must sit above the half bit");
	end

	if (axd_pkg::PREFIX_LSB != axd_pkg::CHSEL_LSB + $clog2(axd_pkg::NUM_CH)) begin : g_chk_chsel
		$error("axd_code_regs: channel select must sit below the prefix");
	end

	if ($bits(axd_pkg::LOW_RST) != axd_pkg::LOW_W) begin : g_chk_low_rst
		$error("axd_code_regs: low reset value width mismatch");
	end

	if ($bits(axd_pkg::HIGH_RST) != axd_pkg::HIGH_W) begin : g_chk_high_rst
		$error("axd_code_regs: high reset value width mismatch");
	end

	if ($bits(axd_pkg::CODE_RST) != axd_pkg::CODE_W) begin : g_chk_code_rst
		$error("axd_code_regs: code reset value width mismatch");
	end

	if ($bits(axd_pkg::WMC_RST) != axd_pkg::WMC_W) begin : g_chk_wmc_rst
		$error("axd_code_regs: control reset value width mismatch");
	end

	// Register table must agree with the decode above
	if (axd_pkg::IDX_DAC1_CODE_LOW != {axd_pkg::CODE_BANK_PREFIX, 2'h0, 1'b0}) begin : g_chk_r0
		$error("axd_code_regs: channel 1 low index off the bank form");
	end

	if (axd_pkg::IDX_DAC1_CODE_HIGH != {axd_pkg::CODE_BANK_PREFIX, 2'h0, 1'b1}) begin : g_chk_r1
		$error("axd_code_regs: channel 1 high index off the bank form");
	end

	if (axd_pkg::IDX_DAC2_CODE_LOW != {axd_pkg::CODE_BANK_PREFIX, 2'h1, 1'b0}) begin : g_chk_r2
		$error("axd_code_regs: channel 2 low index off the bank form");
	end

	if (axd_pkg::IDX_DAC2_CODE_HIGH != {axd_pkg::CODE_BANK_PREFIX, 2'h1, 1'b1}) begin : g_chk_r3
		$error("axd_code_regs: channel 2 high index off the bank form");
	end

	if (axd_pkg::IDX_DAC3_CODE_LOW != {axd_pkg::CODE_BANK_PREFIX, 2'h2, 1'b0}) begin : g_chk_r4
		$error("axd_code_regs: channel 3 low index off the bank form");
	end

	if (axd_pkg::IDX_DAC3_CODE_HIGH != {axd_pkg::CODE_BANK_PREFIX, 2'h2, 1'b1}) begin : g_chk_r5
		$error("axd_code_regs: channel 3 high index off the bank form");
	end

	if (axd_pkg::IDX_DAC4_CODE_LOW != {axd_pkg::CODE_BANK_PREFIX, 2'h3, 1'b0}) begin : g_chk_r6
		$error("axd_code_regs: channel 4 low index off the bank form");
	end

	if (axd_pkg::IDX_DAC4_CODE_HIGH != {axd_pkg::CODE_BANK_PREFIX, 2'h3, 1'b1}) begin : g_chk_r7
		$error("axd_code_regs: channel 4 high index off the bank form");
	end

	if (axd_pkg::IDX_WAVE_MEMORY_CONTROL[6:3] == axd_pkg::CODE_BANK_PREFIX) begin : g_chk_ctl
		$error("axd_code_regs: control register falls inside the bank");
	end

	logic                      ack_q;
	logic [7:0]                rdat_q;
	logic [5:0]                wmc_q;
	logic [9:0]                drive_q;
	logic [1:0]                low_q   [axd_pkg::NUM_CH];
	logic [7:0]                high_q  [axd_pkg::NUM_CH];
	logic [9:0]                code_q  [axd_pkg::NUM_CH];
	logic [7:0]                low_rd  [axd_pkg::NUM_CH];
	logic [7:0]                high_rd [axd_pkg::NUM_CH];

	wire logic                 req     = wb_cyc_i & wb_stb_i;
	wire logic [6:0]           idx     = wb_adr_i[axd_pkg::IDX_LSB +: axd_pkg::IDX_W];
	wire logic                 upper_z;
	wire logic                 in_bank;
	wire logic                 is_wmc;
	wire logic [1:0]           chsel   = idx[axd_pkg::CHSEL_LSB +: 2];
	wire logic                 hi_sel  = idx[axd_pkg::HL_BIT];
	wire logic                 wr_go   = req & ack_q & wb_we_i & wb_sel_i[0];
	wire logic                 src_sel = wmc_q[axd_pkg::WMC_SRC_SEL_BIT];
	logic      [7:0]           rd_mux;

	generate
		if (ADR_W > axd_pkg::IDX_W + axd_pkg::IDX_LSB) begin : g_up
			assign upper_z = ~|wb_adr_i[ADR_W-1:axd_pkg::IDX_W + axd_pkg::IDX_LSB];
		end else begin : g_noup
			assign upper_z = 1'b1;
		end
	endgenerate

	// Bank decode on the 0011 prefix; channel and half come from the low bits
	assign in_bank = upper_z
		& (idx[6:axd_pkg::PREFIX_LSB] == axd_pkg::CODE_BANK_PREFIX); // [RQ10] [RQ1]
	assign is_wmc  = upper_z & (idx == axd_pkg::IDX_WAVE_MEMORY_CONTROL);

	// Read selection; reserved bits read as zero
	always_comb begin
		rd_mux = 8'h00;
		if (in_bank && hi_sel) begin
			rd_mux = high_rd[chsel]; // [RQ8] [RQ9]
		end else if (in_bank) begin
			rd_mux = low_rd[chsel]; // [RQ7] [RQ6]
		end else if (is_wmc) begin
			rd_mux = {{(axd_pkg::REG_W - axd_pkg::WMC_W){1'b0}}, wmc_q}; // [RQ11]
		end
	end

	// Bus answer: one wait cycle, then ack for one cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req & ~ack_q;
		end
	end

	// Read data taken on the edge that raises ack, so it stands while ack is high
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdat_q <= 8'h00;
		end else begin
			rdat_q <= rd_mux;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wmc_q <= axd_pkg::WMC_RST;
		end else if (wr_go && is_wmc) begin
			wmc_q <= wb_dat_i[axd_pkg::WMC_W-1:0]; // [RQ11]
		end
	end

	genvar ch;
	generate
		for (ch = 0; ch < axd_pkg::NUM_CH; ch++) begin : g_ch
			wire logic hit_lo = wr_go & in_bank & ~hi_sel & (chsel == 2'(ch)); // [RQ9]
			wire logic hit_hi = wr_go & in_bank & hi_sel & (chsel == 2'(ch)); // [RQ9]
			wire logic load   = hit_hi & ((ch != 0) | ~src_sel); // [RQ4]

			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					low_q[ch] <= axd_pkg::LOW_RST;
				end else if (hit_lo) begin
					low_q[ch] <= wb_dat_i[axd_pkg::LOW_W-1:0]; // [RQ2] [RQ5]
				end
			end

			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					high_q[ch] <= axd_pkg::HIGH_RST;
				end else if (hit_hi) begin
					high_q[ch] <= wb_dat_i[axd_pkg::HIGH_W-1:0]; // [RQ3]
				end
			end

			// New high byte merged with held low bits in one load
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					code_q[ch] <= axd_pkg::CODE_RST;
				end else if (load) begin
					code_q[ch] <= {wb_dat_i[axd_pkg::HIGH_W-1:0], low_q[ch]}; // [RQ3] [RQ13]
				end
			end

			// Read taps; reserved low bits read as zero
			assign low_rd[ch]  = {{(axd_pkg::REG_W - axd_pkg::LOW_W){1'b0}}, low_q[ch]}; // [RQ6]
			assign high_rd[ch] = high_q[ch];

			assign converter_code_o[ch*axd_pkg::CODE_W +: axd_pkg::CODE_W] = code_q[ch];
		end
	endgenerate

	// Channel 1 source: wave memory or its code register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			drive_q <= axd_pkg::CODE_RST;
		end else begin
			drive_q <= src_sel ? wave_memory_data_i : code_q[0]; // [RQ12]
		end
	end

	assign wb_ack_o              = ack_q;
	assign wb_dat_o              = {{(32 - axd_pkg::REG_W){1'b0}}, rdat_q};
	assign wave_memory_control_o = wmc_q;
	assign converter1_drive_o    = drive_q;

endmodule // axd_code_regs

`default_nettype wire

// ### test/axd_wave_src.sv
// Purpose: Wave memory sample source
// Assumes: Same clock as the bank
// Notes:   Steps every cycle so a stale sample shows
`timescale 1ns/1ps
`default_nettype none
module axd_wave_src (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	output logic      [9:0] wave_memory_data_o
);
	always_ff @(posedge clk_i) wave_memory_data_o <= rst_i ? 10'h0 : wave_memory_data_o + 10'h7;
endmodule // axd_wave_src
`default_nettype wire

// ### test/axd_code_regs_checker.sv
// Purpose: Bus and load checks
// Assumes: One clock
// Notes:   Bound to the bank
`timescale 1ns/1ps
`default_nettype none
module axd_code_regs_checker (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic        wb_ack_o,
	input wire logic [31:0] wb_dat_o,
	input wire logic [9:0]  wave_memory_data_i,
	input wire logic [39:0] converter_code_o,
	input wire logic [9:0]  converter1_drive_o,
	input wire logic [5:0]  wave_memory_control_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
	sequence s_wr; wb_ack_o && wb_we_i; endsequence
	property p_ack; s_req |=> wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("ack late");
	property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
	a_pulse: assert property (p_pulse) else $error("ack long");
	property p_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
	a_cause: assert property (p_cause) else $error("ack unasked");
	property p_idle; !wb_cyc_i |=> !wb_ack_o; endproperty
	a_idle: assert property (p_idle) else $error("ack idle");
	property p_rdhi; wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0; endproperty
	a_rdhi: assert property (p_rdhi) else $error("read top");
	property p_code; !s_wr |=> $stable(converter_code_o); endproperty
	a_code: assert property (p_code) else $error("code moved");
	property p_ctl; !s_wr |=> $stable(wave_memory_control_o); endproperty
	a_ctl: assert property (p_ctl) else $error("ctl moved");
	property p_drv; 1'b1 |=> converter1_drive_o == ($past(wave_memory_control_o[0]) ?
		$past(wave_memory_data_i) : $past(converter_code_o[9:0])); endproperty
	a_drv: assert property (p_drv) else $error("drive src");
endmodule // axd_code_regs_checker
bind axd_code_regs axd_code_regs_checker chk_u (.*);
`default_nettype wire

// ### test/axd_code_regs_test.sv
// Purpose: Bus-level test of the code bank
// Assumes: Ack comes within a few cycles
// Notes:   Expected codes kept in exp_q
`timescale 1ns/1ps
`default_nettype none
module axd_code_regs_test;
	logic        clk_i = 1'b0, rst_i = 1'b1, wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
	logic        wb_ack_o;
	logic [3:0]  wb_sel_i = 4'h1;
	logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o, rd_v;
	logic [39:0] converter_code_o, exp_q = 40'h0;
	logic [9:0]  wave_memory_data_i, converter1_drive_o;
	logic [5:0]  wave_memory_control_o;
	int          n_errors = 0, n_checks = 0, cyc_n = 0;
	axd_code_regs dut_u (.*);
	axd_wave_src wave_u (.clk_i(clk_i), .rst_i(rst_i), .wave_memory_data_o(wave_memory_data_i));
	initial forever #5 clk_i = ~clk_i;
	task automatic bus(input logic [6:0] idx, input logic we, input logic [7:0] d);
		@(posedge clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, 23'h0, idx, 2'h0, 24'h0, d};
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		rd_v = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'h0;
		@(negedge clk_i);
	endtask
	task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cyc_n <= cyc_n + 1;
		if (cyc_n == 3000) begin
			n_errors++;
			complete_run();
		end
	end
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int c = 0; c < 4; c++) begin
			bus(7'h18 + 7'(2 * c), 1'b1, 8'h3);
			chk("low", converter_code_o, exp_q);
			bus(7'h19 + 7'(2 * c), 1'b1, 8'h81 + 8'(c));
			exp_q[c * 10 +: 10] = {8'h81 + 8'(c), 2'h3};
			chk("code", converter_code_o, exp_q);
			bus(7'h18 + 7'(2 * c), 1'b0, 8'h0);
			chk("low rd", 40'(rd_v), 40'h3);
			bus(7'h19 + 7'(2 * c), 1'b0, 8'h0);
			chk("high rd", 40'(rd_v), 40'(8'h81 + 8'(c)));
		end
		$display("map done");
		bus(7'h1b, 1'b1, 8'h22);
		exp_q[19:10] = {8'h22, 2'h3};
		chk("8bit", converter_code_o, exp_q);
		bus(7'h0c, 1'b1, 8'h3f);
		chk("ctl", 40'(wave_memory_control_o), 40'h3f);
		bus(7'h19, 1'b1, 8'h55);
		bus(7'h0c, 1'b1, 8'h0);
		@(negedge clk_i);
		chk("frozen", converter_code_o, exp_q);
		chk("drive", 40'(converter1_drive_o), 40'(exp_q[9:0]));
		bus(7'h19, 1'b0, 8'h0);
		chk("held hi", 40'(rd_v), 40'h55);
		@(posedge clk_i) wb_sel_i <= 4'h0;
		bus(7'h1d, 1'b1, 8'hee);
		@(posedge clk_i) wb_sel_i <= 4'h1;
		chk("sel0", converter_code_o, exp_q);
		bus(7'h20, 1'b1, 8'h77);
		bus(7'h20, 1'b0, 8'h0);
		chk("unmapped", 40'(rd_v), 40'h0);
		$display("edge cases done");
		complete_run();
	end
endmodule // axd_code_regs_test
`default_nettype wire
